// ### logic/wps_pkg.sv
// constants, field layout and mode codes of the wlan power sequencer
// assumes one 50 MHz clock and a plain register port with byte addresses
package wps_pkg;

    localparam int WPS_NRES      = 8;
    localparam int WPS_NCLK      = 4;
    localparam int WPS_RET_DEPTH = 8;

    localparam logic [7:0] WPS_ADR_CTRL    = 8'h00;
    localparam logic [7:0] WPS_ADR_MINMASK = 8'h04;
    localparam logic [7:0] WPS_ADR_STATE   = 8'h08;
    localparam logic [7:0] WPS_ADR_PEND    = 8'h0C;
    localparam logic [7:0] WPS_ADR_CLKMAP  = 8'h10;
    localparam logic [7:0] WPS_ADR_TIMER   = 8'h14;
    localparam logic [7:0] WPS_ADR_STATUS  = 8'h18;
    localparam logic [2:0] WPS_ADR_RC_HI   = 3'h2;

    localparam int WPS_CTRL_PD_LSB   = 0;
    localparam int WPS_CTRL_SLEEP    = 2;
    localparam int WPS_RC_DEP_LSB    = 0;
    localparam int WPS_RC_ON_LSB     = 8;
    localparam int WPS_RC_OFF_LSB    = 16;
    localparam int WPS_TMR_CNT_LSB   = 0;
    localparam int WPS_TMR_MASK_LSB  = 16;
    localparam int WPS_STAT_MODE_LSB = 0;
    localparam int WPS_STAT_WAKE_LSB = 4;

    localparam logic [7:0] WPS_MIN_MASK_RST = 8'h01;
    localparam logic [7:0] WPS_ON_DLY_RST   = 8'h02;
    localparam logic [7:0] WPS_OFF_DLY_RST  = 8'h01;
    localparam logic [7:0] WPS_DEP_RST      = 8'h00;
    localparam logic [1:0] WPS_PD_RST       = 2'h3;

    typedef enum logic [2:0] {
        WPS_OFF     = 3'b000,
        WPS_ACTIVE  = 3'b001,
        WPS_SAVE    = 3'b010,
        WPS_SLEEP   = 3'b011,
        WPS_RESTORE = 3'b100
    } wps_mode_e;

endpackage : wps_pkg

// ### logic/wps_retention_mem.sv
// always-on retention storage for the digital core state
// assumes the same clock as the sequencer; read data is registered
`timescale 1ns/1ps
`default_nettype none
module wps_retention_mem (
    input  wire logic        mclk,
    input  wire logic        we,
    input  wire logic [2:0]  waddr,
    input  wire logic [31:0] wdata,
    input  wire logic [2:0]  raddr,
    output var  logic [31:0] rdata
);
    logic [31:0] mem [wps_pkg::WPS_RET_DEPTH];

    // no reset: contents must survive the sleep, not the power cycle
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : wps_retention_mem
`default_nettype wire

// ### logic/wps_sequencer.sv
// wlan power sequencer: resource table, sleep/retention control, enable pins
// assumes pins and the oscillator are asynchronous; core ports share mclk
`timescale 1ns/1ps
`default_nettype none
module wps_sequencer (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output var  logic [31:0] regRdata,
    input  wire logic        lowPowerOscClock,
    input  wire logic        wlanPowerEnableIn,
    input  wire logic        bluetoothPowerEnableIn,
    input  wire logic        extIrq,
    input  wire logic        hostResume,
    input  wire logic [3:0]  coreClkReq,
    input  wire logic [31:0] coreStateIn,
    output var  logic [7:0]  resourceEnable,
    output var  logic        regulatorEnable,
    output var  logic        wlanResetN,
    output var  logic        mainClockEnable,
    output var  logic [1:0]  clockSpeed,
    output var  logic [1:0]  pullDownEnable,
    output var  logic        ioIsolate,
    output var  logic        coreSaveActive,
    output var  logic [2:0]  coreSaveAddr,
    output var  logic        coreRestoreValid,
    output var  logic [2:0]  coreRestoreAddr,
    output var  logic [31:0] coreRestoreData
);
    typedef struct packed {
        logic [3:0]             pinS1;
        logic [3:0]             pinS2;
        logic                   lpoS1;
        logic                   lpoS2;
        logic                   lpoS3;
        wps_pkg::wps_mode_e     mode;
        logic [3:0]             idx;
        logic                   sleepReq;
        logic [2:0]             wakeCause;
        logic [7:0]             minResourceMask;
        logic [31:0]            clkMap;
        logic [7:0][7:0]        dep;
        logic [7:0][7:0]        onDly;
        logic [7:0][7:0]        offDly;
        logic [7:0]             resourceEnabledFlag;
        logic [7:0]             resourceTransitionPending;
        logic [7:0][7:0]        resTimer;
        logic [15:0]            reqTimer;
        logic [7:0]             reqMask;
        logic [7:0]             reqSet;
        logic [31:0]            rdata;
        logic                   regEn;
        logic                   wlanRstN;
        logic                   mainClkEn;
        logic [1:0]             clkSpeed;
        logic [1:0]             pullDownEn;
        logic                   ioIso;
        logic                   saveActive;
        logic [2:0]             saveAddr;
        logic                   restoreValid;
        logic [2:0]             restoreAddr;
    } wps_state_s;

    wps_state_s  st;
    wps_state_s  nxt_st;
    logic        tick;
    logic        wlanOn;
    logic        btOn;
    logic        timerWake;
    logic [7:0]  clkRes;
    logic [7:0]  depReady;
    logic [7:0]  hasDependents;
    logic        memWe;
    logic [2:0]  memAddr;
    logic [31:0] memRdata;

    // cold-start image, also used for the shutdown soft reset
    function automatic wps_state_s wps_cold_state();
        wps_state_s r;
        r                 = '0;
        r.minResourceMask = wps_pkg::WPS_MIN_MASK_RST;
        r.pullDownEn      = wps_pkg::WPS_PD_RST;
        r.ioIso           = 1'b1;
        for (int i = 0; i < wps_pkg::WPS_NRES; i++) begin
            r.dep[i]    = wps_pkg::WPS_DEP_RST;
            r.onDly[i]  = wps_pkg::WPS_ON_DLY_RST;
            r.offDly[i] = wps_pkg::WPS_OFF_DLY_RST;
        end
        return r;
    endfunction : wps_cold_state

    // a resource pulls in all its dependencies, transitively
    function automatic logic [7:0] wps_closure(input logic [7:0] seed,
                                               input logic [7:0][7:0] dep);
        logic [7:0] r;
        r = seed;
        for (int k = 0; k < wps_pkg::WPS_NRES; k++) begin
            for (int i = 0; i < wps_pkg::WPS_NRES; i++) begin
                if (r[i]) begin
                    r = r | dep[i];
                end
            end
        end
        return r;
    endfunction : wps_closure

    function automatic logic wps_is_rescfg(input logic [7:0] a);
        return (a[7:5] == wps_pkg::WPS_ADR_RC_HI) && (a[1:0] == 2'h0);
    endfunction : wps_is_rescfg

    assign memWe   = (st.mode == wps_pkg::WPS_SAVE);
    assign memAddr = st.idx[2:0];

    wps_retention_mem u_ret (
        .mclk  (mclk),
        .we    (memWe),
        .waddr (memAddr),
        .wdata (coreStateIn),
        .raddr (memAddr),
        .rdata (memRdata)
    );

    always_comb begin
        nxt_st    = st;
        timerWake = 1'b0;
        clkRes    = '0;
        // first stages only feed second stages
        nxt_st.pinS1 = {hostResume, extIrq, bluetoothPowerEnableIn, wlanPowerEnableIn};
        nxt_st.pinS2 = st.pinS1;
        nxt_st.lpoS1 = lowPowerOscClock;
        nxt_st.lpoS2 = st.lpoS1;
        nxt_st.lpoS3 = st.lpoS2;
        tick   = st.lpoS2 & ~st.lpoS3;
        wlanOn = st.pinS2[0];
        btOn   = st.pinS2[1];

        // cores are unclocked outside active mode, so their requests are ignored
        for (int c = 0; c < wps_pkg::WPS_NCLK; c++) begin
            if (coreClkReq[c] && st.mode == wps_pkg::WPS_ACTIVE) begin
                clkRes = clkRes | st.clkMap[c*8 +: 8];
            end
        end
        nxt_st.reqSet = wps_closure(st.minResourceMask | clkRes
                                    | ((st.reqTimer != '0) ? st.reqMask : 8'h00),
                                    st.dep);

        if (tick && st.reqTimer != '0) begin
            nxt_st.reqTimer = st.reqTimer - 16'h0001;
            timerWake       = (st.reqTimer == 16'h0001);
        end

        depReady      = st.resourceEnabledFlag & ~st.resourceTransitionPending;
        hasDependents = '0;
        for (int i = 0; i < wps_pkg::WPS_NRES; i++) begin
            for (int j = 0; j < wps_pkg::WPS_NRES; j++) begin
                if (j != i && st.dep[j][i]
                    && (st.resourceEnabledFlag[j] || st.resourceTransitionPending[j])) begin
                    hasDependents[i] = 1'b1;
                end
            end
        end

        // state bit plus pending bit give the four resource states
        for (int i = 0; i < wps_pkg::WPS_NRES; i++) begin
            if (tick) begin
                if (st.resTimer[i] != 8'h00) begin
                    nxt_st.resTimer[i] = st.resTimer[i] - 8'h01;
                    if (st.resTimer[i] == 8'h01) begin
                        nxt_st.resourceTransitionPending[i] = 1'b0;
                        nxt_st.resourceEnabledFlag[i] = ~st.resourceEnabledFlag[i];
                    end
                end else if (st.resourceEnabledFlag[i] && !st.reqSet[i]
                             && !hasDependents[i]) begin
                    if (st.offDly[i] == 8'h00) begin
                        nxt_st.resourceEnabledFlag[i] = 1'b0;
                    end else begin
                        nxt_st.resTimer[i] = st.offDly[i];
                        nxt_st.resourceTransitionPending[i] = 1'b1;
                    end
                end else if (!st.resourceEnabledFlag[i] && st.reqSet[i]
                             && ((st.dep[i] & ~depReady) == 8'h00)) begin
                    if (st.onDly[i] == 8'h00) begin
                        nxt_st.resourceEnabledFlag[i] = 1'b1;
                    end else begin
                        nxt_st.resTimer[i] = st.onDly[i];
                        nxt_st.resourceTransitionPending[i] = 1'b1;
                    end
                end
            end
        end

        unique case (st.mode)
            wps_pkg::WPS_OFF: begin
                nxt_st.mode = wps_pkg::WPS_ACTIVE;
            end
            wps_pkg::WPS_ACTIVE: begin
                if (st.sleepReq) begin
                    nxt_st.mode     = wps_pkg::WPS_SAVE;
                    nxt_st.idx      = 4'h0;
                    nxt_st.sleepReq = 1'b0;
                end
            end
            wps_pkg::WPS_SAVE: begin
                nxt_st.idx = st.idx + 4'h1;
                if (st.idx == 4'h7) begin
                    nxt_st.mode = wps_pkg::WPS_SLEEP;
                end
            end
            wps_pkg::WPS_SLEEP: begin
                if (timerWake || st.pinS2[2] || st.pinS2[3]) begin
                    nxt_st.mode      = wps_pkg::WPS_RESTORE;
                    nxt_st.idx       = 4'h0;
                    nxt_st.wakeCause = {st.pinS2[3], st.pinS2[2], timerWake};
                end
            end
            wps_pkg::WPS_RESTORE: begin
                nxt_st.idx = st.idx + 4'h1;
                if (st.idx == 4'h8) begin
                    nxt_st.mode = wps_pkg::WPS_ACTIVE;
                end
            end
            default: begin
                nxt_st.mode = wps_pkg::WPS_OFF;
            end
        endcase

        nxt_st.saveActive   = (nxt_st.mode == wps_pkg::WPS_SAVE);
        nxt_st.saveAddr     = nxt_st.idx[2:0];
        nxt_st.restoreValid = (st.mode == wps_pkg::WPS_RESTORE) && !st.idx[3];
        nxt_st.restoreAddr  = st.idx[2:0];
        nxt_st.mainClkEn    = (nxt_st.mode != wps_pkg::WPS_SLEEP);
        nxt_st.clkSpeed     = 2'h0;
        if (st.mode == wps_pkg::WPS_ACTIVE) begin
            // slowest clock that covers the highest request, gated when idle
            if (coreClkReq[3] || coreClkReq[2]) begin
                nxt_st.clkSpeed = 2'h3;
            end else if (coreClkReq[1]) begin
                nxt_st.clkSpeed = 2'h2;
            end else if (coreClkReq[0]) begin
                nxt_st.clkSpeed = 2'h1;
            end
        end

        // software writes come after the mode logic so a set beats the hardware clear
        if (regWr) begin
            unique case (regAddr)
                wps_pkg::WPS_ADR_CTRL: begin
                    nxt_st.pullDownEn = ~regWdata[wps_pkg::WPS_CTRL_PD_LSB +: 2];
                    if (regWdata[wps_pkg::WPS_CTRL_SLEEP]) begin
                        nxt_st.sleepReq = 1'b1;
                    end
                end
                wps_pkg::WPS_ADR_MINMASK: nxt_st.minResourceMask = regWdata[7:0];
                wps_pkg::WPS_ADR_CLKMAP:  nxt_st.clkMap = regWdata;
                wps_pkg::WPS_ADR_TIMER: begin
                    nxt_st.reqTimer = regWdata[wps_pkg::WPS_TMR_CNT_LSB +: 16];
                    nxt_st.reqMask  = regWdata[wps_pkg::WPS_TMR_MASK_LSB +: 8];
                end
                default: begin
                    if (wps_is_rescfg(regAddr)) begin
                        nxt_st.dep[regAddr[4:2]]    = regWdata[wps_pkg::WPS_RC_DEP_LSB +: 8];
                        nxt_st.onDly[regAddr[4:2]]  = regWdata[wps_pkg::WPS_RC_ON_LSB +: 8];
                        nxt_st.offDly[regAddr[4:2]] = regWdata[wps_pkg::WPS_RC_OFF_LSB +: 8];
                    end
                end
            endcase
        end

        nxt_st.rdata = '0;
        if (regRd) begin
            unique case (regAddr)
                wps_pkg::WPS_ADR_CTRL:    nxt_st.rdata = {29'h0, st.sleepReq, ~st.pullDownEn};
                wps_pkg::WPS_ADR_MINMASK: nxt_st.rdata = {24'h0, st.minResourceMask};
                wps_pkg::WPS_ADR_STATE:   nxt_st.rdata = {24'h0, st.resourceEnabledFlag};
                wps_pkg::WPS_ADR_PEND:    nxt_st.rdata = {24'h0, st.resourceTransitionPending};
                wps_pkg::WPS_ADR_CLKMAP:  nxt_st.rdata = st.clkMap;
                wps_pkg::WPS_ADR_TIMER:   nxt_st.rdata = {8'h0, st.reqMask, st.reqTimer};
                wps_pkg::WPS_ADR_STATUS:  nxt_st.rdata = {25'h0, st.wakeCause, 1'b0, st.mode};
                default: begin
                    if (wps_is_rescfg(regAddr)) begin
                        nxt_st.rdata = {8'h0, st.offDly[regAddr[4:2]],
                                        st.onDly[regAddr[4:2]], st.dep[regAddr[4:2]]};
                    end
                end
            endcase
        end

        nxt_st.regEn    = wlanOn | btOn;
        nxt_st.wlanRstN = wlanOn;
        nxt_st.ioIso    = 1'b0;
        if (!wlanOn) begin
            // wlan held in reset: all but the pin and oscillator synchronizers, regulator enable and isolation return to the cold-start image
            nxt_st          = wps_cold_state();
            nxt_st.pinS1    = {hostResume, extIrq, bluetoothPowerEnableIn, wlanPowerEnableIn};
            nxt_st.pinS2    = st.pinS1;
            nxt_st.lpoS1    = lowPowerOscClock;
            nxt_st.lpoS2    = st.lpoS1;
            nxt_st.lpoS3    = st.lpoS2;
            nxt_st.regEn    = btOn;
            nxt_st.ioIso    = !btOn;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= wps_cold_state();
        end else begin
            st <= nxt_st;
        end
    end

    assign regRdata         = st.rdata;
    assign resourceEnable   = st.resourceEnabledFlag;
    assign regulatorEnable  = st.regEn;
    assign wlanResetN       = st.wlanRstN;
    assign mainClockEnable  = st.mainClkEn;
    assign clockSpeed       = st.clkSpeed;
    assign pullDownEnable   = st.pullDownEn;
    assign ioIsolate        = st.ioIso;
    assign coreSaveActive   = st.saveActive;
    assign coreSaveAddr     = st.saveAddr;
    assign coreRestoreValid = st.restoreValid;
    assign coreRestoreAddr  = st.restoreAddr;
    assign coreRestoreData  = memRdata;

    // checks
    logic [7:0] tmrNz;
    always_comb begin
        tmrNz = '0;
        for (int i = 0; i < wps_pkg::WPS_NRES; i++) begin
            tmrNz[i] = (st.resTimer[i] != 8'h00);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_pend_timer;
        st.resourceTransitionPending == tmrNz;
    endproperty
    a_pend_timer: assert property (p_pend_timer) else $error("pending bits disagree with timers");

    property p_reg_or;
        ##1 regulatorEnable == $past(st.pinS2[0] | st.pinS2[1]);
    endproperty
    a_reg_or: assert property (p_reg_or) else $error("regulator enable is not the or");

    property p_wlan_reset;
        !st.pinS2[0] |=> !wlanResetN ##0 st.mode == wps_pkg::WPS_OFF;
    endproperty
    a_wlan_reset: assert property (p_wlan_reset) else $error("wlan not held in reset");

    property p_sleep_clk;
        st.mode == wps_pkg::WPS_SLEEP |-> !mainClockEnable;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("main clock runs in deep sleep");

    property p_save_first;
        $rose(st.mode == wps_pkg::WPS_SLEEP) |-> $past(st.mode) == wps_pkg::WPS_SAVE
            && $past(st.mode, 8) == wps_pkg::WPS_SAVE;
    endproperty
    a_save_first: assert property (p_save_first) else $error("sleep without full save");

    property p_wake;
        st.mode == wps_pkg::WPS_SLEEP && st.pinS2[3] && st.pinS2[0]
            |=> st.mode == wps_pkg::WPS_RESTORE ##9 st.mode == wps_pkg::WPS_ACTIVE;
    endproperty
    a_wake: assert property (p_wake) else $error("host resume did not restore");

    property p_tick_only;
        ##1 (resourceEnable != $past(resourceEnable)) && $past(st.pinS2[0]) |-> $past(tick);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("resource moved without tick");

    property p_pd_default;
        $past(rst) |-> pullDownEnable == wps_pkg::WPS_PD_RST;
    endproperty
    a_pd_default: assert property (p_pd_default) else $error("pull-downs off after reset");

    property p_shutdown;
        !st.pinS2[0] && !st.pinS2[1] |=> ioIsolate && resourceEnable == 8'h00;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not isolated");

    property p_done_toggle;
        ##1 $past(st.pinS2[0]) |-> (($past(st.resourceTransitionPending)
            & ~st.resourceTransitionPending)
            & ~($past(st.resourceEnabledFlag) ^ st.resourceEnabledFlag)) == 8'h00;
    endproperty
    a_done_toggle: assert property (p_done_toggle) else $error("completion did not toggle");

    c_sleep:   cover property (st.mode == wps_pkg::WPS_SAVE ##8 st.mode == wps_pkg::WPS_SLEEP);
    c_restore: cover property (st.mode == wps_pkg::WPS_RESTORE ##9 st.mode == wps_pkg::WPS_ACTIVE);
    c_res_on:  cover property ($rose(st.resourceTransitionPending[1]));
    c_twake:   cover property (timerWake && st.mode == wps_pkg::WPS_SLEEP);

endmodule : wps_sequencer
`default_nettype wire

// ### dv/wps_host_model.sv
// host-side model: both power enables and a free-running oscillator
// assumes the bench asks for enable levels in the mclk domain
`timescale 1ns/1ps
`default_nettype none
module wps_host_model #(
    parameter int HALF = 30
) (
    input  wire logic mclk,
    input  wire logic wantWlan,
    input  wire logic wantBt,
    output var  logic wlanPowerEnableIn,
    output var  logic bluetoothPowerEnableIn,
    output var  logic lowPowerOscClock
);
    int cnt = 0;
    initial begin
        wlanPowerEnableIn      = 1'b0;
        bluetoothPowerEnableIn = 1'b0;
        lowPowerOscClock       = 1'b0;
    end
    // oscillator sped up so that timed transitions fit a short run
    always @(posedge mclk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) lowPowerOscClock <= ~lowPowerOscClock;
        wlanPowerEnableIn      <= wantWlan;
        bluetoothPowerEnableIn <= wantBt;
    end
endmodule : wps_host_model
`default_nettype wire

// ### dv/tb.sv
// bench for the wlan power sequencer: random core words, hand corner cases
// assumes the host model drives enables and oscillator
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        mclk, rst, regWr, regRd, extIrq, hostResume, wantWlan, wantBt, wlanEn, btEn, low_power_osc_clock;
    logic        regEn, wlanResetN, mainClk, ioIsolate, saveAct, restValid;
    logic [1:0]  clockSpeed, pullDownEnable;
    logic [2:0]  saveAddr, restAddr;
    logic [3:0]  coreClkReq;
    logic [7:0]  regAddr, resEn;
    logic [31:0] regWdata, regRdata, d, restData;
    logic [31:0] words [8];
    int          error_cnt = 0, tests_run = 0, cyc = 0, n;
    wps_sequencer wps_sequencer_i (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .lowPowerOscClock(low_power_osc_clock),
        .wlanPowerEnableIn(wlanEn), .bluetoothPowerEnableIn(btEn), .extIrq(extIrq),
        .hostResume(hostResume), .coreClkReq(coreClkReq), .coreStateIn(words[saveAddr]),
        .resourceEnable(resEn), .regulatorEnable(regEn), .wlanResetN(wlanResetN),
        .mainClockEnable(mainClk), .clockSpeed(clockSpeed), .pullDownEnable(pullDownEnable),
        .ioIsolate(ioIsolate), .coreSaveActive(saveAct), .coreSaveAddr(saveAddr),
        .coreRestoreValid(restValid), .coreRestoreAddr(restAddr), .coreRestoreData(restData));
    wps_host_model wps_host_model_i (.mclk(mclk), .wantWlan(wantWlan), .wantBt(wantBt),
        .wlanPowerEnableIn(wlanEn), .bluetoothPowerEnableIn(btEn), .lowPowerOscClock(low_power_osc_clock));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic stop_test;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= v;
        @(posedge mclk);
        regWr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd   <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    // bounded poll; the caller compares what was last read
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        for (int i = 0; i < 200 && (d & m) !== v; i++) rd(a);
    endtask : poll
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            stop_test();
        end
    end
    // resource 2 must never be on while resource 3, which it needs, is off
    always @(negedge mclk) if (resEn[2] && !resEn[3]) chk("dep order", resEn, 8'h08);
    initial begin
        void'($urandom(69252));
        rst = 1'b1;
        {regWr, regRd, regAddr, regWdata, extIrq, hostResume, coreClkReq, wantWlan, wantBt} = '0;
        foreach (words[i]) words[i] = $urandom;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1 chk("pulldown", 32'(pullDownEnable), 32'h3);
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            {wantWlan, wantBt} <= 2'(k);
            repeat (8) @(posedge mclk);
            #1 chk("regulator", 32'(regEn), 32'(k != 0));
            chk("wlan reset", 32'(wlanResetN), 32'(k >> 1));
            chk("isolate", 32'(ioIsolate), 32'(k == 0));
        end
        rd(wps_pkg::WPS_ADR_MINMASK);
        chk("min mask", d, 32'h1);
        rd(8'h40);
        chk("rescfg0", d, 32'h00010200);
        rd(8'h3C);
        chk("unmapped", d, 32'h0);
        poll(wps_pkg::WPS_ADR_PEND, 1, 1);
        chk("pending", d & 1, 1);
        rd(wps_pkg::WPS_ADR_STATE);
        chk("turning on", d & 1, 0);
        poll(wps_pkg::WPS_ADR_STATE, 1, 1);
        chk("enabled", 32'(resEn[0]), 1);
        rd(wps_pkg::WPS_ADR_PEND);
        chk("pend clear", d & 1, 0);
        wr(8'h44, 32'h00010001);
        wr(wps_pkg::WPS_ADR_MINMASK, 32'h3);
        poll(wps_pkg::WPS_ADR_STATE, 2, 2);
        chk("zero delay", d & 2, 2);
        wr(8'h48, 32'h00010008);
        wr(wps_pkg::WPS_ADR_CLKMAP, 32'h4);
        @(posedge mclk);
        coreClkReq <= 4'h1;
        poll(wps_pkg::WPS_ADR_STATE, 32'hC, 32'hC);
        chk("clock request", d & 32'hC, 32'hC);
        chk("clock speed", 32'(clockSpeed), 32'h1);
        @(posedge mclk);
        coreClkReq <= 4'h0;
        poll(wps_pkg::WPS_ADR_STATE, 32'hC, 0);
        chk("released", d & 32'hC, 0);
        chk("speed gated", 32'(clockSpeed), 32'h0);
        wr(wps_pkg::WPS_ADR_TIMER, 32'h00100005);
        poll(wps_pkg::WPS_ADR_STATE, 32'h10, 32'h10);
        chk("timer on", d & 32'h10, 32'h10);
        poll(wps_pkg::WPS_ADR_STATE, 32'h10, 0);
        chk("timer off", d & 32'h10, 0);
        wr(wps_pkg::WPS_ADR_CTRL, 32'h4);
        n = 0;
        repeat (20) begin
            @(posedge mclk);
            #1 n += saveAct;
        end
        chk("save words", n, 8);
        chk("main clock off", 32'(mainClk), 0);
        @(posedge mclk);
        hostResume <= 1'b1;
        n = 0;
        repeat (30) begin
            @(posedge mclk);
            #1 if (restValid === 1'b1) begin
                n++;
                chk("restore", restData, words[restAddr]);
            end
        end
        @(posedge mclk);
        hostResume <= 1'b0;
        chk("restore words", n, 8);
        rd(wps_pkg::WPS_ADR_STATUS);
        chk("status", d & 32'h47, 32'h41);
        chk("main clock on", 32'(mainClk), 1);
        // second sleep woken by the request timer, third by the interrupt pin
        wr(wps_pkg::WPS_ADR_TIMER, 32'h00000003);
        wr(wps_pkg::WPS_ADR_CTRL, 32'h4);
        poll(wps_pkg::WPS_ADR_STATUS, 32'h77, 32'h11);
        chk("timer wake", d & 32'h77, 32'h11);
        wr(wps_pkg::WPS_ADR_CTRL, 32'h4);
        repeat (20) @(posedge mclk);
        chk("asleep", 32'(mainClk), 0);
        @(posedge mclk);
        extIrq <= 1'b1;
        poll(wps_pkg::WPS_ADR_STATUS, 32'h77, 32'h21);
        chk("irq wake", d & 32'h77, 32'h21);
        @(posedge mclk);
        extIrq <= 1'b0;
        wr(wps_pkg::WPS_ADR_CTRL, 32'h3);
        rd(wps_pkg::WPS_ADR_CTRL);
        chk("pd readback", d & 3, 3);
        chk("pd off", 32'(pullDownEnable), 0);
        @(posedge mclk);
        wantWlan <= 1'b0;
        repeat (8) @(posedge mclk);
        wantWlan <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(wps_pkg::WPS_ADR_MINMASK);
        chk("cold start", d, 32'h1);
        stop_test();
    end
endmodule : tb
`default_nettype wire
